// file: rtl/mode_regs_defines.svh
// Offsets, field positions, codes and reset values of the mode registers
`ifndef MODE_REGS_DEFINES_SVH
`define MODE_REGS_DEFINES_SVH
`define ADDR_REFRESH_STATUS   8'h04
`define ADDR_MAKER_ID         8'h05
`define ADDR_REVISION_ONE     8'h06
`define ADDR_REVISION_TWO     8'h07
`define ADDR_GEOMETRY         8'h08
`define ADDR_VENDOR_TEST      8'h09
`define ADDR_IO_CALIBRATION   8'h0A
`define ADDR_TERMINATION      8'h0B
`define TUF_BIT               7
`define RATE_MSB              2
`define RATE_RESET            3'h3
`define RATE_LOW_LIMIT        3'h0
`define RATE_HIGH_LIMIT       3'h7
`define DEVICE_TYPE_S8        2'h3
`define DENSITY_4GB           4'h6
`define DENSITY_6GB           4'hE
`define DENSITY_8GB           4'h7
`define DENSITY_16GB          4'h8
`define DENSITY_32GB          4'h9
`define WIDTH_X32             2'h0
`define WIDTH_X16             2'h1
`define CAL_INIT_CODE         8'hFF
`define CAL_LONG_CODE         8'hAB
`define CAL_SHORT_CODE        8'h56
`define CAL_RESET_CODE        8'hC3
`define TERM_RESET            2'h0
`define PD_TERM_RESET         1'b0
`define TEST_RESET            8'h00
`define MAKER_ID_DEFAULT      8'h5A
`define REVISION_ONE_DEFAULT  8'h11
`define REVISION_TWO_DEFAULT  8'h22
`define ZQI_COMMAND_ADDRESS_SUPPLY_CODE        2'h1
`define ZQI_OK_CODE           2'h3
`endif

// file: rtl/mode_regs_pkg.sv
// Types shared by the mode register bank
package mode_regs_pkg;
  typedef enum logic [2:0] {
    CAL_NONE_TYPE  = 3'h0,
    CAL_INIT_TYPE  = 3'h1,
    CAL_LONG_TYPE  = 3'h2,
    CAL_SHORT_TYPE = 3'h3,
    CAL_RESET_TYPE = 3'h4
  } cal_cmd_type;
  typedef enum logic [1:0] {
    TERM_OFF_TYPE     = 2'h0,
    TERM_QUARTER_TYPE = 2'h1,
    TERM_HALF_TYPE    = 2'h2,
    TERM_FULL_TYPE    = 2'h3
  } term_type;
endpackage

// file: rtl/sync_two_ff.sv
// Two flip-flop synchroniser for pin-level inputs
module sync_two_ff #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage_ff <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage_ff <= async_in;
      sync_out <= stage_ff;
    end
  end
endmodule

// file: rtl/mode_regs.sv
// Temperature status, identity, geometry, calibration and termination regs
// Function
// - rate code bits 2:0; 000 low, 111 high
// - codes 001,010,011 mean 4x,2x,1x refresh
// - codes 100,101,110 mean 0.5x,0.25x,0.25x derate
// - update flag set when rate changes
// - reading status register clears update flag
// - update flag zero after power-up
// - rate bit 2 set only above 85C
// - address 05 returns read-only maker code
// - addresses 06 and 07 return revision codes
// - geometry: type 11, density code bits 5:2
// - geometry bits 7:6 give bus width
// - decode four calibration command codes
// - reserved calibration codes start nothing
// - calibration pin at supply starts no calibration
// - init calibration updates pin connection status
// - termination bits 1:0 select strength
// - termination bit 2 keeps power-down termination
// - reserved bits read back as zero
// - writes to read-only registers do nothing
`include "mode_regs_defines.svh"
module mode_regs
  import mode_regs_pkg::*;
#(
  parameter logic [7:0] MAKER_ID     = `MAKER_ID_DEFAULT, // Arbitrary value
  parameter logic [7:0] REVISION_ONE = `REVISION_ONE_DEFAULT, // Arbitrary
  parameter logic [7:0] REVISION_TWO = `REVISION_TWO_DEFAULT, // Arbitrary
  parameter logic [3:0] DENSITY      = `DENSITY_16GB,
  parameter logic [1:0] BUS_WIDTH    = `WIDTH_X32
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     mr_write,
  input  wire logic                     mr_read,
  input  wire logic [7:0]               mr_addr,
  input  wire logic [7:0]               mr_wdata,
  output logic      [7:0]               mr_rdata,
  output logic                          mr_rvalid,
  output logic                          mr_rhit,
  input  wire logic [2:0]               sensor_rate_pin,
  input  wire logic                     cal_pin_at_supply_pin,
  output mode_regs_pkg::cal_cmd_type    cal_cmd,
  output logic                          cal_start,
  output logic                          default_cal,
  output logic [1:0]                    cal_pin_status,
  output logic                          cal_pin_status_valid,
  output mode_regs_pkg::term_type       data_termination_setting,
  output logic                          powerdown_termination_control,
  output logic [7:0]                    vendor_test_mode,
  output logic                          over_85c
);
  import mode_regs_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [3:0] pins_sync;
  logic [2:0] rate_sync;
  logic       supply_sync;

  // The rate stages reset to the rate register's reset code; a zero there
  // would look like a rate change and raise the update flag after reset.
  sync_two_ff #(
    .WIDTH       (4),
    .RESET_VALUE ({1'b0, `RATE_RESET})
  ) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({cal_pin_at_supply_pin, sensor_rate_pin}),
    .sync_out (pins_sync)
  );

  assign rate_sync   = pins_sync[2:0];
  assign supply_sync = pins_sync[3];

  // ------------------------------------------------------------
  // Refresh rate and update flag
  // ------------------------------------------------------------
  logic [2:0] rate_ff;
  logic       update_flag_ff;
  logic       nxt_update_flag;
  logic       rate_changed;
  logic       status_read;

  assign status_read  = mr_read && (mr_addr == `ADDR_REFRESH_STATUS);
  assign rate_changed = (rate_sync != rate_ff);

  // The sensor code is passed straight through; it carries the meaning
  // of each refresh multiplier, the controller acts on it.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rate_ff <= `RATE_RESET;
    end else begin
      rate_ff <= rate_sync;
    end
  end

  // A change in the same cycle as the read wins over the clear
  always_comb begin
    nxt_update_flag = update_flag_ff;
    if (status_read) begin
      nxt_update_flag = 1'b0;
    end
    if (rate_changed) begin
      nxt_update_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      update_flag_ff <= 1'b0;
    end else begin
      update_flag_ff <= nxt_update_flag;
    end
  end

  assign over_85c = rate_ff[`RATE_MSB];

  // ------------------------------------------------------------
  // Write-only registers
  // ------------------------------------------------------------
  logic [1:0] term_ff;
  logic       pd_term_ff;
  logic [7:0] test_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      term_ff    <= `TERM_RESET;
      pd_term_ff <= `PD_TERM_RESET;
    end else if (mr_write && mr_addr == `ADDR_TERMINATION) begin
      term_ff    <= mr_wdata[1:0];
      pd_term_ff <= mr_wdata[2];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_ff <= `TEST_RESET;
    end else if (mr_write && mr_addr == `ADDR_VENDOR_TEST) begin
      test_ff <= mr_wdata;
    end
  end

  assign data_termination_setting      = term_type'(term_ff);
  assign powerdown_termination_control = pd_term_ff;
  assign vendor_test_mode              = test_ff;

  // ------------------------------------------------------------
  // Calibration command decode
  // ------------------------------------------------------------
  cal_cmd_type cal_decoded;
  cal_cmd_type cal_cmd_ff;
  logic        cal_start_ff;
  logic [1:0]  cal_status_ff;
  logic        cal_status_valid_ff;
  logic        cal_write;

  assign cal_write = mr_write && (mr_addr == `ADDR_IO_CALIBRATION);

  always_comb begin
    case (mr_wdata)
      `CAL_INIT_CODE:  cal_decoded = CAL_INIT_TYPE;
      `CAL_LONG_CODE:  cal_decoded = CAL_LONG_TYPE;
      `CAL_SHORT_CODE: cal_decoded = CAL_SHORT_TYPE;
      `CAL_RESET_CODE: cal_decoded = CAL_RESET_TYPE;
      default:         cal_decoded = CAL_NONE_TYPE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cal_cmd_ff   <= CAL_NONE_TYPE;
      cal_start_ff <= 1'b0;
    end else begin
      cal_start_ff <= 1'b0;
      if (cal_write && cal_decoded != CAL_NONE_TYPE && !supply_sync) begin
        cal_cmd_ff   <= cal_decoded;
        cal_start_ff <= 1'b1;
      end
    end
  end

  // Status of the calibration pin, reported after an init command
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cal_status_ff       <= 2'h0;
      cal_status_valid_ff <= 1'b0;
    end else if (cal_write && cal_decoded == CAL_INIT_TYPE) begin
      cal_status_ff       <= supply_sync ? `ZQI_COMMAND_ADDRESS_SUPPLY_CODE : `ZQI_OK_CODE;
      cal_status_valid_ff <= 1'b1;
    end
  end

  assign cal_cmd              = cal_cmd_ff;
  assign cal_start            = cal_start_ff;
  assign default_cal          = supply_sync;
  assign cal_pin_status       = cal_status_ff;
  assign cal_pin_status_valid = cal_status_valid_ff;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [7:0] nxt_rdata;
  logic       nxt_rhit;
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic       rhit_ff;

  // Writes to read-only addresses fall through: nothing decodes them
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_rhit  = 1'b1;
    case (mr_addr)
      `ADDR_REFRESH_STATUS: nxt_rdata = {update_flag_ff, 4'h0, rate_ff};
      `ADDR_MAKER_ID:       nxt_rdata = MAKER_ID;
      `ADDR_REVISION_ONE:   nxt_rdata = REVISION_ONE;
      `ADDR_REVISION_TWO:   nxt_rdata = REVISION_TWO;
      `ADDR_GEOMETRY: nxt_rdata = {BUS_WIDTH, DENSITY, `DEVICE_TYPE_S8};
      default:              nxt_rhit  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
      rhit_ff   <= 1'b0;
    end else begin
      rvalid_ff <= mr_read;
      rhit_ff   <= mr_read && nxt_rhit;
      if (mr_read) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign mr_rdata  = rdata_ff;
  assign mr_rvalid = rvalid_ff;
  assign mr_rhit   = rhit_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_flag_on_change: assert property (@(posedge core_clk) disable iff (reset)
    rate_changed |=> update_flag_ff)
    else $error("update flag not set after rate change");

  a_flag_read_clear: assert property (@(posedge core_clk) disable iff (reset)
    status_read && !rate_changed |=> !update_flag_ff)
    else $error("update flag not cleared by status read");

  a_flag_holds_low: assert property (@(posedge core_clk) disable iff (reset)
    !update_flag_ff && !rate_changed |=> !update_flag_ff)
    else $error("update flag rose without a rate change");

  a_status_read_data: assert property (@(posedge core_clk) disable iff (reset)
    status_read |=> mr_rvalid && mr_rdata[6:3] == 4'h0
      && mr_rdata[2:0] == $past(rate_ff)
      && mr_rdata[7] == $past(update_flag_ff))
    else $error("status read data wrong");

  a_hot_indicator: assert property (@(posedge core_clk) disable iff (reset)
    over_85c == (rate_ff >= 3'h4))
    else $error("over 85C indicator disagrees with rate code");

  a_geometry_read: assert property (@(posedge core_clk) disable iff (reset)
    mr_read && mr_addr == `ADDR_GEOMETRY |=> mr_rdata[1:0] == 2'h3
      && mr_rdata[7:6] == BUS_WIDTH)
    else $error("geometry read data wrong");

  a_revision_read: assert property (@(posedge core_clk) disable iff (reset)
    mr_read && mr_addr == `ADDR_REVISION_TWO |=> mr_rdata == REVISION_TWO)
    else $error("revision two read data wrong");

  a_cal_reserved: assert property (@(posedge core_clk) disable iff (reset)
    cal_write && cal_decoded == CAL_NONE_TYPE |=> !cal_start)
    else $error("reserved calibration code started calibration");

  a_cal_supply: assert property (@(posedge core_clk) disable iff (reset)
    supply_sync && $past(supply_sync) |-> !cal_start)
    else $error("calibration started with pin at supply");

  a_cal_long: assert property (@(posedge core_clk) disable iff (reset)
    cal_write && mr_wdata == `CAL_LONG_CODE && !supply_sync
      |=> cal_start && cal_cmd == CAL_LONG_TYPE)
    else $error("long calibration not decoded");

  a_term_write: assert property (@(posedge core_clk) disable iff (reset)
    mr_write && mr_addr == `ADDR_TERMINATION
      |=> term_ff == $past(mr_wdata[1:0])
      && pd_term_ff == $past(mr_wdata[2]))
    else $error("termination write not taken");

  a_ro_write: assert property (@(posedge core_clk) disable iff (reset)
    mr_write && mr_addr == `ADDR_GEOMETRY
      |=> $stable(term_ff) && $stable(test_ff) && !cal_start)
    else $error("write to read-only register had an effect");

  a_test_write: assert property (@(posedge core_clk) disable iff (reset)
    mr_write && mr_addr == `ADDR_VENDOR_TEST
      |=> test_ff == $past(mr_wdata))
    else $error("test register write not taken");

  a_read_miss: assert property (@(posedge core_clk) disable iff (reset)
    mr_read && !nxt_rhit |=> mr_rdata == 8'h00 && !mr_rhit)
    else $error("unmapped read returned data or hit");

  a_rvalid_pulse: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> mr_rvalid == $past(mr_read))
    else $error("read valid does not follow read request");

  a_maker_read: assert property (@(posedge core_clk) disable iff (reset)
    mr_read && mr_addr == `ADDR_MAKER_ID |=> mr_rdata == MAKER_ID)
    else $error("maker code read data wrong");

  a_density_read: assert property (@(posedge core_clk) disable iff (reset)
    mr_read && mr_addr == `ADDR_GEOMETRY |=> mr_rdata[5:2] == DENSITY)
    else $error("density code read data wrong");

  a_cal_status: assert property (@(posedge core_clk) disable iff (reset)
    cal_write && cal_decoded == CAL_INIT_TYPE
      |=> cal_pin_status_valid)
    else $error("init calibration did not report pin status");

  a_term_hold: assert property (@(posedge core_clk) disable iff (reset)
    !(mr_write && mr_addr == `ADDR_TERMINATION)
      |=> $stable(term_ff) && $stable(pd_term_ff))
    else $error("termination changed without a write");

  a_rate_follow: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> rate_ff == $past(rate_sync))
    else $error("rate register does not follow the sensor");
endmodule

// file: testbench/mr_host.sv
// Controller model issuing mode register reads and writes
module mr_host (
  input  wire logic       core_clk,
  output logic            mr_write,
  output logic            mr_read,
  output logic [7:0]      mr_addr,
  output logic [7:0]      mr_wdata,
  input  wire logic [7:0] mr_rdata,
  input  wire logic       mr_rvalid,
  input  wire logic       cal_start
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mr_write = 1'b0;
    mr_read  = 1'b0;
    mr_addr  = 8'h00;
    mr_wdata = 8'h00;
  end
  // Released lines show the inverse so no stale value looks valid
  task automatic mr_wr(input logic [7:0] a, input logic [7:0] d,
                       output logic st);
    @(negedge core_clk);
    mr_addr  = a;
    mr_wdata = d;
    mr_write = 1'b1;
    @(negedge core_clk);
    mr_write = 1'b0;
    st       = cal_start;
    mr_addr  = ~a;
    mr_wdata = ~d;
  endtask
  task automatic mr_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge core_clk);
    mr_addr = a;
    mr_read = 1'b1;
    @(negedge core_clk);
    mr_read = 1'b0;
    for (n = 0; n < 4 && mr_rvalid !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    d       = (mr_rvalid === 1'b1) ? mr_rdata : 8'hXX;
    mr_addr = ~a;
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the mode register bank
`include "mode_regs_defines.svh"
module tb;
  import mode_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] sensor_rate_pin = 3'h3;
  logic cal_pin_at_supply_pin = 1'b0;
  logic mr_write, mr_read, mr_rvalid, mr_rhit, cal_start, default_cal;
  logic [7:0] mr_addr, mr_wdata, mr_rdata, vendor_test_mode, rd;
  logic [1:0] cal_pin_status;
  logic cal_pin_status_valid, powerdown_termination_control, over_85c, st;
  cal_cmd_type cal_cmd;
  term_type data_termination_setting;
  int errors = 0;
  int check_count = 0;
  int i;
  logic [7:0] id_exp [5] = '{8'h03, `MAKER_ID_DEFAULT, `REVISION_ONE_DEFAULT,
    `REVISION_TWO_DEFAULT, {`WIDTH_X32, `DENSITY_16GB, `DEVICE_TYPE_S8}};
  logic [7:0] cal_code [4] = '{`CAL_INIT_CODE, `CAL_LONG_CODE,
    `CAL_SHORT_CODE, `CAL_RESET_CODE};
  logic [7:0] wo_addr [4] = '{8'h09, 8'h0A, 8'h0B, 8'h40};

  always #5 core_clk = ~core_clk;

  mr_host host (.core_clk(core_clk), .mr_write(mr_write), .mr_read(mr_read),
    .mr_addr(mr_addr), .mr_wdata(mr_wdata), .mr_rdata(mr_rdata),
    .mr_rvalid(mr_rvalid), .cal_start(cal_start));

  mode_regs uut (.core_clk(core_clk), .reset(reset), .mr_write(mr_write),
    .mr_read(mr_read), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
    .mr_rdata(mr_rdata), .mr_rvalid(mr_rvalid), .mr_rhit(mr_rhit),
    .sensor_rate_pin(sensor_rate_pin),
    .cal_pin_at_supply_pin(cal_pin_at_supply_pin), .cal_cmd(cal_cmd),
    .cal_start(cal_start), .default_cal(default_cal),
    .cal_pin_status(cal_pin_status),
    .cal_pin_status_valid(cal_pin_status_valid),
    .data_termination_setting(data_termination_setting),
    .powerdown_termination_control(powerdown_termination_control),
    .vendor_test_mode(vendor_test_mode), .over_85c(over_85c));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    chk({6'h00, data_termination_setting}, 8'h00);
    chk({7'h00, powerdown_termination_control}, 8'h00);
    chk({5'h00, cal_cmd}, 8'h00);
    host.mr_rd(8'h04, rd);
    chk(rd, 8'h03);
    // Writes to read-only places must leave contents and flag untouched
    for (i = 0; i < 5; i++) begin
      host.mr_wr(8'(8'h04 + i), 8'hFF, st);
      chk({7'h00, st}, 8'h00);
      host.mr_rd(8'(8'h04 + i), rd);
      chk(rd, id_exp[i]);
      chk({7'h00, mr_rhit}, 8'h01);
    end
    for (i = 0; i < 8; i++) begin
      @(negedge core_clk);
      sensor_rate_pin = 3'(i);
      repeat (5) @(negedge core_clk);
      host.mr_rd(`ADDR_REFRESH_STATUS, rd);
      chk(rd, {1'b1, 4'h0, 3'(i)});
      chk({7'h00, over_85c}, {7'h00, i >= 4});
      host.mr_rd(`ADDR_REFRESH_STATUS, rd);
      chk(rd, {1'b0, 4'h0, 3'(i)});
    end
    for (i = 0; i < 4; i++) begin
      host.mr_wr(`ADDR_IO_CALIBRATION, cal_code[i], st);
      chk({7'h00, st}, 8'h01);
      chk({5'h00, cal_cmd}, 8'(i + 1));
    end
    chk({5'h00, cal_pin_status_valid, cal_pin_status}, 8'h07);
    host.mr_wr(`ADDR_IO_CALIBRATION, 8'h57, st);
    chk({7'h00, st}, 8'h00);
    chk({5'h00, cal_cmd}, 8'h04);
    @(negedge core_clk);
    cal_pin_at_supply_pin = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({7'h00, default_cal}, 8'h01);
    host.mr_wr(`ADDR_IO_CALIBRATION, `CAL_LONG_CODE, st);
    chk({7'h00, st}, 8'h00);
    chk({5'h00, cal_cmd}, 8'h04);
    for (i = 0; i < 8; i++) begin
      host.mr_wr(`ADDR_TERMINATION, 8'(i), st);
      chk({6'h00, data_termination_setting}, 8'(i % 4));
      chk({7'h00, powerdown_termination_control}, 8'(i / 4));
    end
    host.mr_wr(`ADDR_VENDOR_TEST, 8'hA5, st);
    chk(vendor_test_mode, 8'hA5);
    // Write-only and unmapped places read as zero with no hit
    for (i = 0; i < 4; i++) begin
      host.mr_rd(wo_addr[i], rd);
      chk(rd, 8'h00);
      chk({7'h00, mr_rhit}, 8'h00);
    end
    end_of_test();
  end

  // Run needs well under 400 cycles; this limit only catches a hang
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule
